// ==== pkg/call_stack_consts.vh ====
// constants for the call stack, table byte and operand access block
`ifndef CALL_STACK_CONSTS_VH
`define CALL_STACK_CONSTS_VH

// ==========================================
// system register offsets, bank 0
`define OFS_TABLE_HIGH      8'h82
`define OFS_STACK_PTR       8'hdf
`define OFS_STACK_BASE      8'hf0
`define STACK_AREA_TAG      4'hf

// ==========================================
// immediate target window
`define IMM_TARGET_LO       8'h80
`define IMM_TARGET_HI       8'h87

// ==========================================
// field positions
`define GIE_BIT             7
`define SP_MSB              2
`define ENTRY_HI_MSB        4

// ==========================================
// reset values
`define SP_RESET            3'h7
`define GIE_RESET           1'h0
`define ENTRY_RESET         13'h0000
`define TABLE_HIGH_RESET    8'h00
`define ACC_RESET           8'h00

// ==========================================
// operand addressing modes
`define MODE_IMMEDIATE      2'h0
`define MODE_DIRECT         2'h1
`define MODE_INDIRECT       2'h2

`endif

// ==== rtl/stack_mem.v ====
// eight-entry by 13-bit return address store with byte writes and registered read
`timescale 1ns/1ps
`include "call_stack_consts.vh"

module stack_mem (
   input  wire        clk,
   input  wire        rst,
   input  wire [2:0]  wr_addr,
   input  wire        wr_hi,
   input  wire        wr_lo,
   input  wire [12:0] wr_data,
   input  wire        rd_en,
   input  wire [2:0]  rd_addr,
   output reg  [12:0] rd_data
);

   reg [12:0] entry [0:7];
   integer    i;

   // ==========================================
   // storage, both halves clear at reset
   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < 8; i = i + 1) begin
            entry[i] <= `ENTRY_RESET;
         end
      end else begin
         if (wr_hi) begin
            entry[wr_addr][12:8] <= wr_data[12:8];
         end
         if (wr_lo) begin
            entry[wr_addr][7:0] <= wr_data[7:0];
         end
      end
   end

   // ==========================================
   // registered read port
   always @(posedge clk) begin
      if (rst) begin
         rd_data <= `ENTRY_RESET;
      end else if (rd_en) begin
         rd_data <= entry[rd_addr];
      end
   end

endmodule // stack_mem

// ==== rtl/operand_addr.v ====
// operand address formation for immediate, direct and indirect modes
`timescale 1ns/1ps
`include "call_stack_consts.vh"

module operand_addr (
   input  wire [1:0] mode,
   input  wire [7:0] addr_field,
   input  wire [7:0] ptr_bank,
   input  wire [7:0] ptr_index,
   output reg  [7:0] bank,
   output reg  [7:0] index,
   output reg        imm_target_ok
);

   // ==========================================
   // bank and location per mode
   always @* begin
      bank          = 8'h00;
      index         = addr_field;
      imm_target_ok = (addr_field >= `IMM_TARGET_LO) && (addr_field <= `IMM_TARGET_HI);
      case (mode)
         `MODE_INDIRECT: begin
            bank  = ptr_bank;
            index = ptr_index;
         end
         default: begin
            bank  = 8'h00;
            index = addr_field;
         end
      endcase
   end

endmodule // operand_addr

// ==== rtl/call_stack_core.v ====
// return address stack, interrupt enable, table high byte and operand moves
`timescale 1ns/1ps
`include "call_stack_consts.vh"

module call_stack_core (
   input  wire        clk,
   input  wire        rst,
   input  wire        push_req,
   input  wire [12:0] push_pc,
   input  wire        pop_sub_req,
   input  wire        pop_irq_req,
   output wire [12:0] ret_pc,
   output reg         ret_valid,
   output reg         ret_from_irq,
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   output reg         reg_rvalid,
   input  wire        table_read,
   input  wire [15:0] table_word,
   input  wire        op_go,
   input  wire [1:0]  op_mode,
   input  wire        op_to_acc,
   input  wire [7:0]  op_addr,
   input  wire [7:0]  op_imm,
   input  wire [7:0]  ptr_bank,
   input  wire [7:0]  ptr_index,
   output reg         op_busy,
   output reg  [7:0]  ram_bank,
   output reg  [7:0]  ram_index,
   output reg         ram_re,
   output reg         ram_we,
   output reg  [7:0]  ram_wdata,
   input  wire [7:0]  ram_rdata,
   output reg  [7:0]  working_sum_register,
   output reg  [7:0]  table_high,
   output reg  [2:0]  stack_pointer_bits,
   output reg         global_irq_enable
);

   // operand sequencer states, one-hot
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ADDR = 3'b010;
   localparam [2:0] ST_DATA = 3'b100;

   reg  [2:0]  state;
   reg  [2:0]  next_state;
   reg  [7:0]  rd_addr_q;
   reg         rd_pend;
   reg  [2:0]  mem_wr_addr;
   reg         mem_wr_hi;
   reg         mem_wr_lo;
   reg  [12:0] mem_wr_data;
   reg         mem_rd_en;
   reg  [2:0]  mem_rd_addr;
   wire [12:0] mem_rd_data;
   wire [7:0]  opd_bank;
   wire [7:0]  opd_index;
   wire        imm_ok;
   wire        pop_req;
   wire        reg_wr_stack;
   wire        reg_rd_stack;

   // ==========================================
   // helpers
   // entry slot written by a push at a given pointer
   function [2:0] push_slot;
      input [2:0] sp;
      begin
         push_slot = ~sp;
      end
   endfunction

   // entry slot addressed by a bank 0 system address
   function [2:0] addr_slot;
      input [7:0] a;
      begin
         addr_slot = ~a[3:1];
      end
   endfunction

   // true when an address lies in the stack entry area
   function in_stack_area;
      input [7:0] a;
      begin
         in_stack_area = (a[7:4] == `STACK_AREA_TAG);
      end
   endfunction

   assign pop_req      = pop_sub_req | pop_irq_req;
   assign reg_wr_stack = reg_wr & in_stack_area(reg_addr);
   assign reg_rd_stack = reg_rd & in_stack_area(reg_addr);
   assign ret_pc       = mem_rd_data;

   // ==========================================
   // entry storage
   stack_mem u_stack_mem (
      .clk     (clk),
      .rst     (rst),
      .wr_addr (mem_wr_addr),
      .wr_hi   (mem_wr_hi),
      .wr_lo   (mem_wr_lo),
      .wr_data (mem_wr_data),
      .rd_en   (mem_rd_en),
      .rd_addr (mem_rd_addr),
      .rd_data (mem_rd_data)
   );

   // ==========================================
   // operand address formation
   operand_addr u_operand_addr (
      .mode          (op_mode),
      .addr_field    (op_addr),
      .ptr_bank      (ptr_bank),
      .ptr_index     (ptr_index),
      .bank          (opd_bank),
      .index         (opd_index),
      .imm_target_ok (imm_ok)
   );

   // ==========================================
   // stack memory write and read selection
   // push beats a software byte write in the same cycle
   always @* begin
      mem_wr_addr = push_slot(stack_pointer_bits);
      mem_wr_hi   = 1'b0;
      mem_wr_lo   = 1'b0;
      mem_wr_data = push_pc;
      if (push_req) begin
         mem_wr_hi = 1'b1;
         mem_wr_lo = 1'b1;
      end else if (reg_wr_stack) begin
         mem_wr_addr = addr_slot(reg_addr);
         mem_wr_hi   = reg_addr[0];
         mem_wr_lo   = ~reg_addr[0];
         mem_wr_data = {reg_wdata[`ENTRY_HI_MSB:0], reg_wdata};
      end
   end

   // pop reads the slot the pointer will point past, else software reads
   always @* begin
      mem_rd_en   = 1'b0;
      mem_rd_addr = addr_slot(reg_addr);
      if (pop_req && !push_req) begin
         mem_rd_en   = 1'b1;
         mem_rd_addr = push_slot(stack_pointer_bits + 3'h1);
      end else if (reg_rd_stack) begin
         mem_rd_en = 1'b1;
      end
   end

   // ==========================================
   // stack pointer and interrupt enable
   always @(posedge clk) begin
      if (rst) begin
         stack_pointer_bits <= `SP_RESET;
         global_irq_enable  <= `GIE_RESET;
      end else begin
         if (push_req) begin
            stack_pointer_bits <= stack_pointer_bits - 3'h1;
         end else if (pop_req) begin
            stack_pointer_bits <= stack_pointer_bits + 3'h1;
         end else if (reg_wr && reg_addr == `OFS_STACK_PTR) begin
            stack_pointer_bits <= reg_wdata[`SP_MSB:0];
         end
         if (reg_wr && reg_addr == `OFS_STACK_PTR) begin
            global_irq_enable <= reg_wdata[`GIE_BIT];
         end
      end
   end

   // ==========================================
   // return strobe, data from memory read port
   always @(posedge clk) begin
      if (rst) begin
         ret_valid    <= 1'b0;
         ret_from_irq <= 1'b0;
      end else begin
         ret_valid    <= pop_req & ~push_req;
         ret_from_irq <= pop_irq_req & ~push_req;
      end
   end

   // ==========================================
   // register read pipeline, two cycles for every offset
   always @(posedge clk) begin
      if (rst) begin
         rd_addr_q  <= 8'h00;
         rd_pend    <= 1'b0;
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         rd_addr_q  <= reg_addr;
         rd_pend    <= reg_rd & ~(pop_req & ~push_req);
         reg_rvalid <= rd_pend;
         if (rd_pend) begin
            if (in_stack_area(rd_addr_q)) begin
               if (rd_addr_q[0]) begin
                  reg_rdata <= {3'h0, mem_rd_data[12:8]};
               end else begin
                  reg_rdata <= mem_rd_data[7:0];
               end
            end else if (rd_addr_q == `OFS_STACK_PTR) begin
               reg_rdata <= {global_irq_enable, 4'h0, stack_pointer_bits};
            end else if (rd_addr_q == `OFS_TABLE_HIGH) begin
               reg_rdata <= table_high;
            end else begin
               reg_rdata <= 8'h00; // unmapped reads as zero
            end
         end
      end
   end

   // ==========================================
   // operand sequencer next state
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            // a table read in the same cycle drops the operation, so no load starts
            if (op_go && !table_read && op_mode != `MODE_IMMEDIATE && op_to_acc) begin
               next_state = ST_ADDR;
            end
         end
         ST_ADDR: begin
            next_state = ST_DATA;
         end
         ST_DATA: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ==========================================
   // sum register, table byte, ram port
   always @(posedge clk) begin
      if (rst) begin
         state                <= ST_IDLE;
         op_busy              <= 1'b0;
         ram_bank             <= 8'h00;
         ram_index            <= 8'h00;
         ram_re               <= 1'b0;
         ram_we               <= 1'b0;
         ram_wdata            <= 8'h00;
         working_sum_register <= `ACC_RESET;
         table_high           <= `TABLE_HIGH_RESET;
      end else begin
         state   <= next_state;
         op_busy <= (next_state != ST_IDLE);
         ram_re  <= 1'b0;
         ram_we  <= 1'b0;
         if (table_read) begin
            table_high           <= table_word[15:8];
            working_sum_register <= table_word[7:0];
         end else if (state == ST_DATA) begin
            working_sum_register <= ram_rdata;
            // software write to the scratch byte still lands while a load finishes
            if (reg_wr && reg_addr == `OFS_TABLE_HIGH) begin
               table_high <= reg_wdata;
            end
         end else if (state == ST_IDLE && op_go) begin
            ram_bank  <= opd_bank;
            ram_index <= opd_index;
            if (op_mode == `MODE_IMMEDIATE) begin
               if (op_to_acc) begin
                  working_sum_register <= op_imm;
               end else if (imm_ok && op_addr == `OFS_TABLE_HIGH) begin
                  table_high <= op_imm;
               end else if (imm_ok) begin
                  ram_we    <= 1'b1;
                  ram_wdata <= op_imm;
               end
            end else if (op_to_acc) begin
               ram_re <= 1'b1;
            end else begin
               ram_we    <= 1'b1;
               ram_wdata <= working_sum_register;
            end
         end else if (reg_wr && reg_addr == `OFS_TABLE_HIGH) begin
            table_high <= reg_wdata;
         end
      end
   end

endmodule // call_stack_core

// ==== bench/ram_partner.sv ====
// data memory model on the far side of the operand port
`timescale 1ns/1ps
module ram_partner (
   input  wire       clk,
   input  wire [7:0] ram_bank,
   input  wire [7:0] ram_index,
   input  wire [7:0] ram_wdata,
   input  wire       ram_re,
   input  wire       ram_we,
   output reg  [7:0] ram_rdata
);
   reg [7:0] mem [0:65535];
   initial ram_rdata = 8'h00;
   // store, answer a read next cycle, else scramble the idle bus
   always @(posedge clk) begin
      if (ram_we) mem[{ram_bank, ram_index}] <= ram_wdata;
      ram_rdata <= ram_re ? mem[{ram_bank, ram_index}] : ~ram_rdata;
   end
endmodule // ram_partner

// ==== bench/call_stack_props.sv ====
// port assertions for the call stack block
`timescale 1ns/1ps
module call_stack_props (
   input wire        clk,
   input wire        rst,
   input wire        push_req,
   input wire        pop_sub_req,
   input wire        pop_irq_req,
   input wire [2:0]  stack_pointer_bits,
   input wire        ret_valid,
   input wire        ret_from_irq,
   input wire        reg_rd,
   input wire        reg_wr,
   input wire [7:0]  reg_addr,
   input wire [7:0]  reg_wdata,
   input wire        reg_rvalid,
   input wire        table_read,
   input wire [15:0] table_word,
   input wire [7:0]  table_high,
   input wire [7:0]  working_sum_register,
   input wire        op_go,
   input wire        op_busy,
   input wire [1:0]  op_mode,
   input wire        op_to_acc,
   input wire [7:0]  op_addr,
   input wire [7:0]  ptr_bank,
   input wire [7:0]  ptr_index,
   input wire [7:0]  ram_bank,
   input wire [7:0]  ram_index,
   input wire        ram_we,
   input wire        ram_re,
   input wire        global_irq_enable
);
   // ==========================================
   // helpers
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire pop_any = (pop_sub_req | pop_irq_req) & ~push_req;
   wire op_ok   = op_go & ~op_busy & ~table_read;
   sequence load_issue; ram_re && op_busy; endsequence
   sequence load_wait; !ram_re && op_busy; endsequence
   // ==========================================
   // assertions
   a_push_step: assert property (
      push_req |=> stack_pointer_bits == $past(stack_pointer_bits) - 3'h1) else $error("push step wrong");
   a_pop_return: assert property (
      pop_any |=> ret_valid && ret_from_irq == $past(pop_irq_req)
         && stack_pointer_bits == $past(stack_pointer_bits) + 3'h1) else $error("pop wrong");
   a_read_latency: assert property (
      reg_rd && !pop_any |-> ##2 reg_rvalid) else $error("read answer late");
   a_table_load: assert property (
      table_read |=> {table_high, working_sum_register} == $past(table_word)) else $error("table load wrong");
   a_gie_write: assert property (
      reg_wr && reg_addr == 8'hdf |=> {global_irq_enable, 7'h00} == ($past(reg_wdata) & 8'h80))
      else $error("irq enable write wrong");
   a_scratch_write: assert property (
      reg_wr && reg_addr == 8'h82 && !table_read && !op_go |=> table_high == $past(reg_wdata))
      else $error("scratch write wrong");
   a_load_steps: assert property (
      op_ok && op_to_acc && op_mode != 2'h0 |=> load_issue ##1 load_wait ##1 !op_busy) else $error("load steps");
   a_direct_addr: assert property (
      op_ok && op_mode == 2'h1 |=> ram_bank == 8'h00 && ram_index == $past(op_addr)) else $error("direct addr");
   a_indirect_addr: assert property (
      op_ok && op_mode == 2'h2 |=> ram_bank == $past(ptr_bank) && ram_index == $past(ptr_index))
      else $error("indirect addr");
   a_imm_window: assert property (
      op_ok && op_mode == 2'h0 && !op_to_acc && (op_addr < 8'h80 || op_addr > 8'h87) |=> !ram_we)
      else $error("immediate store outside window");
endmodule // call_stack_props
bind call_stack_core call_stack_props i_props (.*);

// ==== bench/call_stack_core_tb.sv ====
// self-checking bench for the call stack block
`timescale 1ns/1ps
module call_stack_core_tb;
   reg         clk = 0, rst = 1, push_req = 0, pop_sub_req = 0, pop_irq_req = 0, reg_wr = 0, reg_rd = 0;
   reg         table_read = 0, op_go = 0, op_to_acc = 0;
   reg  [12:0] push_pc = 0;
   reg  [7:0]  reg_addr = 0, reg_wdata = 0, op_addr = 0, op_imm = 0, ptr_bank = 0, ptr_index = 0, v, w, a;
   reg  [15:0] table_word = 0;
   reg  [1:0]  op_mode = 0;
   reg  [2:0]  p;
   reg  [12:0] pcs [0:8];
   wire [12:0] ret_pc;
   wire        ret_valid, ret_from_irq, reg_rvalid, op_busy, ram_re, ram_we, global_irq_enable;
   wire [7:0]  reg_rdata, ram_bank, ram_index, ram_wdata, ram_rdata, working_sum_register, table_high;
   wire [2:0]  stack_pointer_bits;
   integer     error_cnt = 0, compares = 0, i;
   always #5 clk = ~clk;
   call_stack_core i_dut (.*);
   ram_partner i_ram (.*);
   // ==========================================
   // shared tasks
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         compares = compares + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task tick; begin @(posedge clk); #1; end endtask
   task rd(input [7:0] ad, input [7:0] e);
      begin reg_addr = ad; reg_rd = 1; tick; reg_rd = 0; tick; chk(reg_rvalid, 1); chk(reg_rdata, e); end
   endtask
   task wr(input [7:0] ad, input [7:0] d);
      begin reg_addr = ad; reg_wdata = d; reg_wr = 1; tick; reg_wr = 0; tick; end
   endtask
   task op(input [1:0] m, input t, input [7:0] ad, input [7:0] im);
      begin
         op_mode = m; op_to_acc = t; op_addr = ad; op_imm = im; op_go = 1;
         tick; op_go = 0; tick; tick; tick;
      end
   endtask
   task report_and_stop;
      begin
         $display("compares %0d errors %0d", compares, error_cnt);
         if (error_cnt == 0 && compares > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   // ==========================================
   // watchdog
   initial begin #200000; error_cnt = error_cnt + 1; report_and_stop; end
   // ==========================================
   // tests
   initial begin
      i = $urandom(41);
      repeat (8) @(posedge clk);
      #1 rst = 0;
      rd(8'hdf, 8'h07);
      rd(8'hfe, 8'h00);
      v = $urandom; wr(8'h82, v); rd(8'h82, v);
      wr(8'hf1, 8'hff); rd(8'hf1, 8'h1f);
      wr(8'h90, v); rd(8'h90, 8'h00);
      $display("test registers done");
      // eight back-to-back pushes, then read the entries
      for (i = 0; i < 9; i = i + 1) pcs[i] = $urandom;
      push_req = 1;
      for (i = 0; i < 8; i = i + 1) begin
         push_pc = pcs[i]; p = 3'h6 - i[2:0]; tick; chk(stack_pointer_bits, p);
      end
      push_req = 0;
      for (i = 0; i < 8; i = i + 1) begin
         rd(8'hf0 + 2 * (7 - i), pcs[i][7:0]);
         rd(8'hf1 + 2 * (7 - i), {3'h0, pcs[i][12:8]});
      end
      // pops alternate both exit kinds
      for (i = 7; i >= 0; i = i - 1) begin
         pop_irq_req = i[0]; pop_sub_req = !i[0]; p = 3'h7 - i[2:0]; tick;
         chk(ret_valid, 1); chk(ret_from_irq, i[0]);
         chk(ret_pc, pcs[i]); chk(stack_pointer_bits, p);
      end
      pop_irq_req = 0; pop_sub_req = 0;
      $display("test stack done");
      // ninth push overflows
      push_req = 1;
      for (i = 0; i < 9; i = i + 1) begin push_pc = pcs[i]; tick; end
      push_req = 0; chk(stack_pointer_bits, 3'h6);
      pop_sub_req = 1; tick; pop_sub_req = 0; chk(ret_pc, pcs[8]);
      wr(8'hdf, 8'h87); rd(8'hdf, 8'h87); chk(global_irq_enable, 1);
      wr(8'hdf, 8'h07); chk(global_irq_enable, 0); chk(stack_pointer_bits, 3'h7);
      $display("test overflow done");
      table_word = $urandom; table_read = 1; tick; table_read = 0;
      chk({table_high, working_sum_register}, table_word);
      // operand modes with random data and addresses
      repeat (4) begin
         v = $urandom; w = ~v; a = $urandom;
         op(2'h0, 1'h1, 8'h00, v); chk(working_sum_register, v);
         op(2'h0, 1'h0, 8'h82, w); chk(table_high, w);
         op(2'h0, 1'h0, 8'h90, w); op(2'h0, 1'h0, 8'h85, v); op(2'h0, 1'h1, 8'h00, w);
         op(2'h1, 1'h1, 8'h85, 8'h00); chk(working_sum_register, v);
         op(2'h1, 1'h0, a, 8'h00); ptr_bank = 0; ptr_index = a; op(2'h0, 1'h1, 8'h00, w);
         op(2'h2, 1'h1, 8'h00, 8'h00); chk(working_sum_register, v);
         ptr_bank = $urandom; op(2'h2, 1'h0, 8'h00, 8'h00); op(2'h0, 1'h1, 8'h00, w);
         op(2'h2, 1'h1, 8'h00, 8'h00); chk(working_sum_register, v);
      end
      // scratch write in the last cycle of a direct load
      op_mode = 2'h1; op_to_acc = 1; op_addr = 8'h85; op_go = 1; tick; op_go = 0; tick;
      reg_addr = 8'h82; reg_wdata = a; reg_wr = 1; tick; reg_wr = 0; tick;
      chk(table_high, a); chk(working_sum_register, v);
      $display("test operands done");
      report_and_stop;
   end
endmodule // call_stack_core_tb
